/* File: rtl/gdio_pkg.sv */
// constants shared by the general digital io port design
package gdio_pkg;
    localparam int         GDIO_PINS     = 8;
    localparam int         GDIO_ADDR_W   = 4;
    // register byte offsets
    localparam logic [3:0] GDIO_OFS_OUT  = 4'h0;
    localparam logic [3:0] GDIO_OFS_DIR  = 4'h4;
    localparam logic [3:0] GDIO_OFS_IN   = 4'h8;
    localparam logic [3:0] GDIO_OFS_CTRL = 4'hC;
    // field positions and reset values
    localparam int         GDIO_PUD_BIT  = 0;
    localparam logic [7:0] GDIO_RST_OUT  = 8'h00;
    localparam logic [7:0] GDIO_RST_DIR  = 8'h00;
    localparam logic       GDIO_RST_PUD  = 1'h0;
    localparam logic [7:0] GDIO_RST_SYNC = 8'h00;
    // bus answers
    localparam logic [1:0] GDIO_OKAY     = 2'h0;
    localparam logic [1:0] GDIO_SLVERR   = 2'h2;
    // write channel states
    typedef enum logic [1:0] {
        GDIO_WR_IDLE = 2'h1,
        GDIO_WR_RESP = 2'h2
    } gdio_wr_state_t;
endpackage

/* File: rtl/gdio_pin_if.sv */
// control and sample signals between register logic and the pad cells
`timescale 1ns/10ps
interface gdio_pin_if #(parameter int N = 8);
    logic [N-1:0] dir;
    logic [N-1:0] out_val;
    logic         global_pullup_disable;
    logic [N-1:0] alt_en;
    logic [N-1:0] alt_oe;
    logic [N-1:0] alt_out;
    logic [N-1:0] pin_sync;
    modport ctrl (output dir, out_val, global_pullup_disable, alt_en, alt_oe, alt_out,
                  input pin_sync);
    modport pad (input dir, out_val, global_pullup_disable, alt_en, alt_oe, alt_out,
                 output pin_sync);
endinterface

/* File: rtl/gdio_pad_cell.sv */
// per-pin drivers, pull-up control and input synchronisers
`timescale 1ns/10ps
module gdio_pad_cell
    import gdio_pkg::*;
#(
    parameter int N = GDIO_PINS
)
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // register side
    gdio_pin_if.pad           pins,
    // pads
    input  wire logic [N-1:0] pad_in,
    output logic      [N-1:0] pad_out,
    output logic      [N-1:0] pad_oe,
    output logic      [N-1:0] pad_pullup
);
    logic [N-1:0] sync_a;
    logic [N-1:0] sync_b;
    logic [N-1:0] next_sync_a;
    logic [N-1:0] next_sync_b;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_pin
            logic oe_i;
            logic val_i;
            // alternate function only touches its own pin
            assign oe_i  = pins.alt_en[i] ? pins.alt_oe[i] : pins.dir[i];
            assign val_i = pins.alt_en[i] ? pins.alt_out[i]
                                          : pins.out_val[i];
            // reset gates the drivers without any clock edge
            assign pad_oe[i]     = aresetn & oe_i;
            assign pad_out[i]    = aresetn & oe_i & val_i;
            assign pad_pullup[i] = aresetn & ~oe_i & pins.out_val[i]
                                   & ~pins.alt_en[i] & ~pins.global_pullup_disable;
        end
    endgenerate

    always_comb
    begin
        next_sync_a = pad_in;
        next_sync_b = sync_a;
        if (!aresetn)
        begin
            next_sync_a = GDIO_RST_SYNC;
            next_sync_b = GDIO_RST_SYNC;
        end
    end

    // two-stage capture of the pin levels
    always_ff @(posedge aclk)
    begin
        sync_a <= next_sync_a;
        sync_b <= next_sync_b;
    end

    assign pins.pin_sync = sync_b;
endmodule // gdio_pad_cell

/* File: rtl/gdio_port.sv */
// general digital io port with axi4-lite register access
//
// Contract
// - direction bit one makes the pin an output, zero an input.
// - input pin with data bit one gets its pull-up enabled.
// - output pin drives the data bit value.
// - reset tri-states every pin, without needing a clock.
// - writing one to the input register toggles the data bit.
// - input register is read-only storage; data and direction read/write.
// - global pull-up disable turns off every pull-up.
// - changing one bit leaves the other pins untouched.
// - three separate registers, one bit per pin at the same position.
// - alternate function on some pins leaves the others unchanged.
// - pin level is synchronised before reaching the input register.
// - a driven level reads back through the same synchroniser.
`timescale 1ns/10ps
module gdio_port
    import gdio_pkg::*;
#(
    parameter int N = GDIO_PINS
)
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address
    input  wire logic [GDIO_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]             s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read
    input  wire logic [GDIO_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic      [31:0]            s_axi_rdata,
    output logic      [1:0]             s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // alternate function overrides
    input  wire logic [N-1:0]           alt_en,
    input  wire logic [N-1:0]           alt_oe,
    input  wire logic [N-1:0]           alt_out,
    // pads
    input  wire logic [N-1:0]           pad_in,
    output logic      [N-1:0]           pad_out,
    output logic      [N-1:0]           pad_oe,
    output logic      [N-1:0]           pad_pullup
);
    gdio_pin_if #(.N(N)) pins ();

    // register state
    logic [N-1:0] out_data;
    logic [N-1:0] dir;
    logic         global_pullup_disable;
    logic [N-1:0] next_out_data;
    logic [N-1:0] next_dir;
    logic         next_pud;

    // write channel state
    gdio_wr_state_t            wr_state;
    gdio_wr_state_t            next_wr_state;
    logic                      aw_hold;
    logic                      w_hold;
    logic [GDIO_ADDR_W-1:0]    aw_addr;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic [1:0]                bresp;
    logic                      next_aw_hold;
    logic                      next_w_hold;
    logic [GDIO_ADDR_W-1:0]    next_aw_addr;
    logic [31:0]               next_w_data;
    logic [3:0]                next_w_strb;
    logic [1:0]                next_bresp;

    // read channel state
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      next_rvalid;
    logic [31:0]               next_rdata;
    logic [1:0]                next_rresp;

    // write decode helpers
    logic                      aw_take;
    logic                      w_take;
    logic                      wr_fire;
    logic [GDIO_ADDR_W-1:0]    wa;
    logic [31:0]               wd;
    logic [3:0]                ws;
    logic                      wr_in;
    logic                      wr_out;
    logic                      wr_dir;

    assign s_axi_awready = !aw_hold && (wr_state == GDIO_WR_IDLE);
    assign s_axi_wready  = !w_hold && (wr_state == GDIO_WR_IDLE);
    assign s_axi_bvalid  = (wr_state == GDIO_WR_RESP);
    assign s_axi_bresp   = bresp;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wa      = aw_hold ? aw_addr : s_axi_awaddr;
    assign wd      = w_hold ? w_data : s_axi_wdata;
    assign ws      = w_hold ? w_strb : s_axi_wstrb;
    assign wr_fire = (aw_hold || aw_take) && (w_hold || w_take);
    assign wr_in   = wr_fire && (wa == GDIO_OFS_IN) && ws[0];
    assign wr_out  = wr_fire && (wa == GDIO_OFS_OUT) && ws[0];
    assign wr_dir  = wr_fire && (wa == GDIO_OFS_DIR) && ws[0];

    always_comb
    begin
        next_wr_state = wr_state;
        next_aw_hold  = aw_hold;
        next_w_hold   = w_hold;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bresp    = bresp;
        case (wr_state)
            GDIO_WR_IDLE:
            begin
                if (aw_take)
                begin
                    next_aw_hold = 1'b1;
                    next_aw_addr = s_axi_awaddr;
                end
                if (w_take)
                begin
                    next_w_hold = 1'b1;
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                end
                if (wr_fire)
                begin
                    next_aw_hold  = 1'b0;
                    next_w_hold   = 1'b0;
                    next_wr_state = GDIO_WR_RESP;
                    case (wa)
                        GDIO_OFS_OUT, GDIO_OFS_DIR,
                        GDIO_OFS_IN, GDIO_OFS_CTRL: next_bresp = GDIO_OKAY;
                        default:                    next_bresp = GDIO_SLVERR;
                    endcase
                end
            end
            GDIO_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_wr_state = GDIO_WR_IDLE;
                end
            end
            default:
            begin
                next_wr_state = GDIO_WR_IDLE;
            end
        endcase
        if (!aresetn)
        begin
            next_wr_state = GDIO_WR_IDLE;
            next_aw_hold  = 1'b0;
            next_w_hold   = 1'b0;
            next_bresp    = GDIO_OKAY;
        end
    end

    always_ff @(posedge aclk)
    begin
        wr_state <= next_wr_state;
        aw_hold  <= next_aw_hold;
        w_hold   <= next_w_hold;
        aw_addr  <= next_aw_addr;
        w_data   <= next_w_data;
        w_strb   <= next_w_strb;
        bresp    <= next_bresp;
    end

    // register file; only byte lane 0 carries pin bits
    always_comb
    begin
        next_out_data = out_data;
        next_dir      = dir;
        next_pud      = global_pullup_disable;
        if (wr_out)
        begin
            next_out_data = wd[N-1:0];
        end
        if (wr_dir)
        begin
            next_dir = wd[N-1:0];
        end
        if (wr_in)
        begin
            next_out_data = out_data ^ wd[N-1:0];
        end
        if (wr_fire && (wa == GDIO_OFS_CTRL) && ws[0])
        begin
            next_pud = wd[GDIO_PUD_BIT];
        end
        if (!aresetn)
        begin
            next_out_data = GDIO_RST_OUT;
            next_dir      = GDIO_RST_DIR;
            next_pud      = GDIO_RST_PUD;
        end
    end

    always_ff @(posedge aclk)
    begin
        out_data <= next_out_data;
        dir      <= next_dir;
        global_pullup_disable      <= next_pud;
    end

    // read channel
    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid)
        begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h00000000;
            next_rresp  = GDIO_OKAY;
            case (s_axi_araddr)
                GDIO_OFS_OUT:  next_rdata[N-1:0] = out_data;
                GDIO_OFS_DIR:  next_rdata[N-1:0] = dir;
                GDIO_OFS_IN:   next_rdata[N-1:0] = pins.pin_sync;
                GDIO_OFS_CTRL: next_rdata[GDIO_PUD_BIT] = global_pullup_disable;
                default:       next_rresp = GDIO_SLVERR;
            endcase
        end
        if (!aresetn)
        begin
            next_rvalid = 1'b0;
            next_rdata  = 32'h00000000;
            next_rresp  = GDIO_OKAY;
        end
    end

    always_ff @(posedge aclk)
    begin
        rvalid <= next_rvalid;
        rdata  <= next_rdata;
        rresp  <= next_rresp;
    end

    assign pins.dir     = dir;
    assign pins.out_val = out_data;
    assign pins.global_pullup_disable     = global_pullup_disable;
    assign pins.alt_en  = alt_en;
    assign pins.alt_oe  = alt_oe;
    assign pins.alt_out = alt_out;

    gdio_pad_cell #(.N(N)) u_pads (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pins       (pins),
        .pad_in     (pad_in),
        .pad_out    (pad_out),
        .pad_oe     (pad_oe),
        .pad_pullup (pad_pullup)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_dir_sets_oe: assert property (
        (pad_oe & ~alt_en) == (dir & ~alt_en))
        else $error("pad enable does not follow direction");
    chk_pullup_gate: assert property (
        (pad_pullup & ~alt_en) == (~dir & out_data & ~alt_en & {N{~global_pullup_disable}}))
        else $error("pull-up state wrong");
    chk_drive_value: assert property (
        (pad_out & dir & ~alt_en) == (out_data & dir & ~alt_en))
        else $error("driven level differs from data bit");
    chk_reset_hiz: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |-> (pad_oe == '0) && (pad_pullup == '0))
        else $error("pin driven during reset");
    chk_toggle_write: assert property (
        wr_in |=> out_data == ($past(out_data) ^ $past(wd[N-1:0])))
        else $error("input write did not toggle data");
    chk_input_readonly: assert property (
        wr_in |=> $stable(dir) && $stable(global_pullup_disable))
        else $error("input write changed other state");
    chk_pud_global: assert property (
        global_pullup_disable |-> pad_pullup == '0)
        else $error("pull-up on while globally disabled");
    chk_bit_isolate: assert property (
        wr_dir && !wr_in |=> $stable(out_data))
        else $error("direction write disturbed data");
    chk_sync_delay: assert property (
        $past(aresetn, 2) |-> pins.pin_sync == $past(pad_in, 2))
        else $error("pin sample delay wrong");
    chk_reset_clear: assert property (
        $rose(aresetn) |-> (dir == '0) && (out_data == '0))
        else $error("registers not cleared by reset");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");

    cov_toggle:  cover property (wr_in ##1 wr_in);
    cov_pullup:  cover property (pad_pullup != '0);
    cov_unmapped: cover property (s_axi_bvalid && s_axi_bresp == GDIO_SLVERR);
    cov_alt_pin: cover property (alt_en != '0 && dir != '0);
endmodule // gdio_port

/* File: bench/gdio_pad_model.sv */
// pad-side model: external drivers, pull-ups and floating pins
`timescale 1ns/10ps
module gdio_pad_model
(
    // clock
    input  wire logic       aclk,
    // device pads
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup,
    // external drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // resolved pin levels
    output logic      [7:0] pin
);
    logic [7:0] flt = 8'h55;

    // an undriven pin without pull-up wanders every cycle
    always @(posedge aclk)
        flt <= ~flt;

    // device driver wins, then external driver, then pull-up
    always_comb
        pin = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
            | (~pad_oe & ~ext_en & (pad_pullup | flt));
endmodule // gdio_pad_model

/* File: bench/gdio_port_tb.sv */
// self-checking bench for the general digital io port
`timescale 1ns/10ps
module gdio_port_tb;
    import gdio_pkg::*;
    typedef struct packed {
        logic [7:0] dir, dat, ee, ev;
        logic       global_pullup_disable;
    } gdio_row_t;

    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, ws;
    logic [7:0]  alt_en = 8'h00, alt_oe = 8'h00, alt_out = 8'h00;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup;
    logic [31:0] rd;
    int          errors = 0, n_compared = 0;

    // order keeps every pin off the forbidden direct transitions
    gdio_row_t rows [11] = '{
        '{8'h00, 8'h00, 8'h0F, 8'h05, 1'h0},
        '{8'h00, 8'hFF, 8'h00, 8'h00, 1'h0},
        '{8'h00, 8'hFF, 8'h0F, 8'h0A, 1'h1},
        '{8'hFF, 8'hA5, 8'h00, 8'h00, 1'h0},
        '{8'hF0, 8'h3C, 8'h03, 8'h01, 1'h0},
        '{8'h0F, 8'h96, 8'hF0, 8'hC0, 1'h1},
        '{8'h0F, 8'h96, 8'h00, 8'h00, 1'h0},
        '{8'h0F, 8'h16, 8'h00, 8'h00, 1'h0},
        '{8'h8F, 8'h16, 8'h00, 8'h00, 1'h0},
        '{8'h8F, 8'h96, 8'h00, 8'h00, 1'h0},
        '{8'h0F, 8'h96, 8'h00, 8'h00, 1'h0}};

    always #12.5 aclk = ~aclk;

    gdio_port #(.N(GDIO_PINS)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .alt_en, .alt_oe, .alt_out, .pad_in, .pad_out, .pad_oe,
        .pad_pullup);

    gdio_pad_model i_pads (.aclk, .pad_out, .pad_oe, .pad_pullup,
        .ext_en, .ext_val, .pin(pad_in));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int   i;
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            // judge the handshake mid-cycle, act on it after the next edge
            @(negedge aclk);
            aw_go = s_axi_awvalid && s_axi_awready;
            w_go  = s_axi_wvalid && s_axi_wready;
            b_go  = s_axi_bvalid;
            if (b_go) ws = s_axi_bresp;
            @(posedge aclk);
            if (aw_go) s_axi_awvalid <= 1'h0;
            if (w_go) s_axi_wvalid <= 1'h0;
            if (b_go) break;
        end
        s_axi_bready <= 1'h0;
        if (i == 40)
        begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic rd_reg(input logic [3:0] a);
        int   i;
        logic ar_go, r_go;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(negedge aclk);
            ar_go = s_axi_arvalid && s_axi_arready;
            r_go  = s_axi_rvalid;
            if (r_go) rd = s_axi_rdata;
            if (r_go) rs = s_axi_rresp;
            @(posedge aclk);
            if (ar_go) s_axi_arvalid <= 1'h0;
            if (r_go) break;
        end
        s_axi_rready <= 1'h0;
        if (i == 40)
        begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic apply_row(input gdio_row_t r);
        wr(GDIO_OFS_CTRL, {7'h00, r.global_pullup_disable});
        wr(GDIO_OFS_OUT, r.dat);
        wr(GDIO_OFS_DIR, r.dir);
        #1;
        chk("bresp", ws, GDIO_OKAY);
        chk("oe", pad_oe, r.dir);
        chk("drive", pad_out, r.dir & r.dat);
        chk("pullup", pad_pullup, ~r.dir & r.dat & {8{~r.global_pullup_disable}});
    endtask

    initial
    begin
        logic [7:0] pu, pv, m;
        repeat (5) @(posedge aclk);
        chk("rst oe", pad_oe, 8'h00);
        chk("rst pu", pad_pullup, 8'h00);
        aresetn <= 1'h1;
        foreach (rows[k])
        begin
            @(posedge aclk);
            ext_en <= rows[k].ee;
            ext_val <= rows[k].ev;
            apply_row(rows[k]);
            pu = ~rows[k].dir & rows[k].dat & {8{~rows[k].global_pullup_disable}};
            pv = (rows[k].dir & rows[k].dat) | pu
               | (~rows[k].dir & rows[k].ee & rows[k].ev);
            m = rows[k].dir | rows[k].ee | pu;
            repeat (3) @(posedge aclk);
            rd_reg(GDIO_OFS_IN);
            chk("in reg", rd & m, pv & m);
            chk("rresp", rs, GDIO_OKAY);
            rd_reg(GDIO_OFS_OUT);
            chk("out reg", rd, rows[k].dat);
            rd_reg(GDIO_OFS_DIR);
            chk("dir reg", rd, rows[k].dir);
        end
        // toggle through the input register
        wr(GDIO_OFS_IN, 8'h3C);
        rd_reg(GDIO_OFS_OUT);
        chk("toggle", rd, 8'h96 ^ 8'h3C);
        rd_reg(GDIO_OFS_DIR);
        chk("dir kept", rd, 8'h0F);
        wr(GDIO_OFS_IN, 8'h00);
        rd_reg(GDIO_OFS_OUT);
        chk("no toggle", rd, 8'h96 ^ 8'h3C);
        // unmapped address: refused with an error, no state touched
        wr(4'h2, 8'hFF);
        chk("bad wr resp", ws, GDIO_SLVERR);
        rd_reg(4'h2);
        chk("bad rd resp", rs, GDIO_SLVERR);
        chk("bad rd data", rd, 32'h00000000);
        rd_reg(GDIO_OFS_OUT);
        chk("bad wr kept", rd, 8'h96 ^ 8'h3C);
        // alternate function on the low nibble only
        @(posedge aclk);
        alt_en <= 8'h0F;
        alt_oe <= 8'h05;
        alt_out <= 8'h01;
        #1;
        chk("alt oe", pad_oe, 8'h05);
        chk("alt pu", pad_pullup, 8'hA0);
        chk("alt out", pad_out & 8'h05, 8'h01);
        // synchroniser delay on an external edge
        @(posedge aclk);
        alt_en <= 8'h00;
        ext_en <= 8'hFF;
        ext_val <= 8'h00;
        repeat (4) @(posedge aclk);
        ext_val <= 8'hFF;
        rd_reg(GDIO_OFS_IN);
        chk("sync old", rd, 8'h0A);
        repeat (3) @(posedge aclk);
        rd_reg(GDIO_OFS_IN);
        chk("sync new", rd, 8'hFA);
        // reset in mid-run reaches the pads before any clock edge
        @(posedge aclk);
        aresetn <= 1'h0;
        #1;
        chk("mid rst oe", pad_oe, 8'h00);
        chk("mid rst pu", pad_pullup, 8'h00);
        chk("mid rst out", pad_out, 8'h00);
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd_reg(GDIO_OFS_OUT);
        chk("rst out reg", rd, GDIO_RST_OUT);
        rd_reg(GDIO_OFS_DIR);
        chk("rst dir reg", rd, GDIO_RST_DIR);
        rd_reg(GDIO_OFS_CTRL);
        chk("rst ctrl", rd, GDIO_RST_PUD);
        tally_and_finish();
    end
endmodule // gdio_port_tb
